/* inc/spi_slave_pkg.sv */
// ============================================================
// shared constants for the serial slave
package spi_slave_pkg;
    // byte width and select-mode codes
    localparam int          BYTE_BITS     = 8;
    localparam logic [1:0]  SEL_THREE_WIRE = 2'h0;
    localparam logic [1:0]  SEL_FOUR_WIRE  = 2'h1;
    // control and status layout (serial_control_register)
    localparam int          XFER_DONE_BIT = 7;
    localparam int          COLLIDE_BIT   = 6;
    localparam int          FAULT_BIT     = 5;
    localparam int          OVERRUN_BIT   = 4;
    localparam int          SELMODE_LSB   = 2;
    localparam int          MASTER_BIT    = 1;
    localparam int          ENABLE_BIT    = 0;
    // flag vector indices (flag_clear_in, flags)
    localparam int          FLAG_OVERRUN  = 0;
    localparam int          FLAG_FAULT    = 1;
    localparam int          FLAG_COLLIDE  = 2;
    localparam int          FLAG_XFER_DONE = 3;
    localparam int          FLAG_COUNT    = 4;
    // reset values
    localparam logic [1:0]  SELMODE_RESET = SEL_FOUR_WIRE;
    localparam logic        ENABLE_RESET  = 1'h0;
    localparam logic        MASTER_ENABLE_RESET   = 1'h0;
    localparam logic [3:0]  FLAGS_RESET   = 4'h0;
    // least select lead before first clock edge, system clocks
    localparam int          SS_LEAD_CLKS  = 2;
    localparam int          SYNC_STAGES   = 2;
endpackage

/* inc/shift_link_if.sv */
`timescale 1ns/1ps
// ============================================================
// carries words between core domain and link domain
interface shift_link_if #(
    parameter int W = 8
);
    logic [W-1:0] load_byte;  // next byte to send, core domain
    logic [W-1:0] rx_word;    // last byte received, link domain
    logic         done_tgl;   // toggles once per finished byte
    logic         miso;       // serial output bit
    logic         first_bit;  // link waits for first edge of byte

    modport core (
        output load_byte,
        input  rx_word,
        input  done_tgl,
        input  miso,
        input  first_bit
    );
    modport link (
        input  load_byte,
        output rx_word,
        output done_tgl,
        output miso,
        output first_bit
    );
endinterface

/* src/bit_sync.sv */
`timescale 1ns/1ps
// ============================================================
// two-flop level synchroniser
module bit_sync
    import spi_slave_pkg::*;
#(
    parameter int           WIDTH = 1,
    parameter logic [0:0]   INIT  = 1'h0
) (
    input  wire logic             clk_in,   // destination clock
    input  wire logic             rst_b_in, // async reset, low
    input  wire logic [WIDTH-1:0] d_in,     // foreign level
    output logic      [WIDTH-1:0] q_out     // synchronised level
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) $error("bit_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta  <= {WIDTH{INIT}};
            q_out <= {WIDTH{INIT}};
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule

/* src/byte_shifter.sv */
`timescale 1ns/1ps
// ============================================================
// link-domain shift engine, runs on the serial clock
module byte_shifter
    import spi_slave_pkg::*;
#(
    parameter int W = BYTE_BITS
) (
    input  wire logic  sck_in,      // serial clock from master
    input  wire logic  rst_b_in,    // global reset, low
    input  wire logic  link_rst_b_in, // counter reset, low
    input  wire logic  mosi_in,     // serial data in
    shift_link_if.link lnk          // words to and from core
);
    localparam int CW = $clog2(W);
    localparam logic [CW-1:0] LAST = CW'(W - 1);

    logic [CW-1:0] bit_cnt;
    logic [W-1:0]  shreg;

    initial begin
        if (W < 2) $error("byte_shifter: W must be at least 2");
    end

    // [RQ14] counts edges
    always_ff @(posedge sck_in or negedge link_rst_b_in) begin
        if (!link_rst_b_in) begin
            bit_cnt <= '0;
            shreg   <= '0;
        end else begin
            bit_cnt <= (bit_cnt == LAST) ? '0 : bit_cnt + 1'b1;
            shreg   <= bit_cnt == '0 ? {lnk.load_byte[W-2:0], mosi_in}
                                     : {shreg[W-2:0], mosi_in};
        end
    end

    // [RQ14] byte handed over
    always_ff @(posedge sck_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lnk.rx_word  <= '0;
            lnk.done_tgl <= 1'b0;
        end else if (link_rst_b_in && bit_cnt == LAST) begin
            lnk.rx_word  <= {shreg[W-2:0], mosi_in};
            lnk.done_tgl <= ~lnk.done_tgl;
        end
    end

    // first bit comes straight from the loaded byte
    assign lnk.first_bit = (bit_cnt == '0);
    assign lnk.miso = lnk.first_bit ? lnk.load_byte[W-1] : shreg[W-1];

    cnt_wrap_a: assert property ( // [RQ14]
        @(posedge sck_in) disable iff (!link_rst_b_in)
        bit_cnt == LAST |=> bit_cnt == '0)
        else $error("bit counter did not wrap after last bit");
endmodule

/* src/spi_slave.sv */
`timescale 1ns/1ps
// ============================================================
// serial peripheral slave: control, flags and buffers
// Operation
// [RQ1] write with empty shift register loads shift register at once
// [RQ2] with shift register busy, buffered byte loads after last edge
// [RQ3] select mode 01 gives default 4-wire slave mode
// [RQ4] 4-wire: active while select low, idle while high
// [RQ5] 4-wire: falling select clears the bit counter
// [RQ6] master drops select two system clocks before first edge
// [RQ7] select mode 00 gives 3-wire mode, select ignored
// [RQ8] 3-wire: only enable off then on resets the bit counter
// [RQ9] transfer-complete flag set after every byte in every mode
// [RQ10] write with full transmit buffer sets collision, write dropped
// [RQ11] master with select low sets mode fault, clears both enables
// [RQ12] byte done with unread receive byte: overrun, old byte kept
// [RQ13] set flags request interrupt when enabled; software clears
// [RQ14] counts edges; after eight bits flag set, byte to buffer
// [RQ15] writes go to transmit buffer first; slave never starts; code loads a write straight into an idle shifter (RQ1)
// [RQ16] disabled: bit counter held at zero, clock ignored
module spi_slave
    import spi_slave_pkg::*;
#(
    parameter int W = BYTE_BITS
) (
    input  wire logic         core_clk_in,   // system clock
    input  wire logic         rst_b_in,      // async reset, low
    input  wire logic         sck_in,        // serial clock pin
    input  wire logic         mosi_in,       // serial data in pin
    input  wire logic         ss_n_in,       // slave select pin
    output logic              miso_out,      // serial data out pin
    output logic              miso_oe_out,   // data out enable
    input  wire logic         ctrl_wr_in,    // control write pulse
    input  wire logic         ctrl_enable_in,  // peripheral_enable
    input  wire logic         ctrl_master_in,  // master_enable
    input  wire logic [1:0]   ctrl_selmode_in, // select mode bits
    input  wire logic [3:0]   flag_clear_in, // flag clear pulses
    input  wire logic         int_enable_in, // interrupt enable
    input  wire logic         data_wr_in,    // data write pulse
    input  wire logic [W-1:0] data_in,       // data write value
    input  wire logic         data_rd_in,    // data read pulse
    output logic      [W-1:0] rx_data_out,   // receive buffer
    output logic      [7:0]   control_out,   // control view
    output logic              irq_req_out,   // interrupt request
    output logic              busy_out       // byte in progress
);
    // ========================================================
    // control state
    logic         peripheral_enable;
    logic         master_enable;
    logic [1:0]   select_mode;
    logic [3:0]   flags;
    logic [3:0]   flag_set;

    // transmit path
    logic [W-1:0] tx_hold;
    logic         tx_full;
    logic         shift_full;

    // receive path
    logic [W-1:0] rx_buf;
    logic         rx_full;

    // crossings
    logic         done_sync;
    logic         done_seen;
    logic         done;
    logic         ss_sync;
    logic         first_sync;

    logic         slave_active;
    logic         four_wire;
    logic         link_rst_b;
    logic         mode_fault;
    logic         collide;
    logic         rx_room;

    shift_link_if #(.W(W)) lnk ();

    initial begin
        if (W != BYTE_BITS) $error("spi_slave: W must equal byte width");
    end

    // ========================================================
    // link domain
    byte_shifter #(
        .W (W)
    ) u_shifter (
        .sck_in        (sck_in),
        .rst_b_in      (rst_b_in),
        .link_rst_b_in (link_rst_b),
        .mosi_in       (mosi_in),
        .lnk           (lnk.link)
    );

    // [RQ3] mode decode
    assign slave_active = peripheral_enable & ~master_enable;
    assign four_wire    = (select_mode == SEL_FOUR_WIRE);

    // [RQ4] select gates link
    // [RQ5] select high clears counter
    // [RQ7] three wire ignores select
    // [RQ16] disabled holds counter
    assign link_rst_b = rst_b_in & slave_active & ~(four_wire & ss_n_in);

    // drive data out while active: only while selected in 4-wire mode, always in other modes
    assign miso_out    = lnk.miso;
    assign miso_oe_out = slave_active & (~four_wire | ~ss_n_in);

    // ========================================================
    // crossings into core domain
    bit_sync #(
        .WIDTH (1),
        .INIT  (1'h0)
    ) u_done_sync (
        .clk_in   (core_clk_in),
        .rst_b_in (rst_b_in),
        .d_in     (lnk.done_tgl),
        .q_out    (done_sync)
    );

    bit_sync #(
        .WIDTH (1),
        .INIT  (1'h1)
    ) u_ss_sync (
        .clk_in   (core_clk_in),
        .rst_b_in (rst_b_in),
        .d_in     (ss_n_in),
        .q_out    (ss_sync)
    );

    bit_sync #(
        .WIDTH (1),
        .INIT  (1'h1)
    ) u_first_sync (
        .clk_in   (core_clk_in),
        .rst_b_in (rst_b_in),
        .d_in     (lnk.first_bit),
        .q_out    (first_sync)
    );

    // [RQ14] byte finished event
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_seen <= 1'b0;
        end else begin
            done_seen <= done_sync;
        end
    end
    assign done = done_sync ^ done_seen;

    // ========================================================
    // control register
    // [RQ11] mode fault in multi-master
    assign mode_fault = peripheral_enable & master_enable
                      & ~select_mode[1] & ~ss_sync;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            peripheral_enable <= ENABLE_RESET;
            master_enable     <= MASTER_ENABLE_RESET;
            select_mode       <= SELMODE_RESET;
        end else if (mode_fault) begin
            // [RQ11] fault clears enables
            peripheral_enable <= 1'b0;
            master_enable     <= 1'b0;
        end else if (ctrl_wr_in) begin
            // [RQ8] enable cycle resets counter
            peripheral_enable <= ctrl_enable_in;
            master_enable     <= ctrl_master_in;
            select_mode       <= ctrl_selmode_in;
        end
    end

    // ========================================================
    // transmit path
    assign collide = data_wr_in & tx_full;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_hold       <= '0;
            tx_full       <= 1'b0;
            shift_full    <= 1'b0;
            lnk.load_byte <= '0;
        end else if (!peripheral_enable) begin
            tx_full    <= 1'b0;
            shift_full <= 1'b0;
        end else if (done) begin
            if (tx_full) begin
                // [RQ2] pending byte after last edge
                lnk.load_byte <= tx_hold;
                tx_full       <= 1'b0;
                shift_full    <= 1'b1;
            end else if (data_wr_in) begin
                lnk.load_byte <= data_in;
                shift_full    <= 1'b1;
            end else begin
                shift_full <= 1'b0;
            end
        end else if (data_wr_in && !tx_full) begin
            if (!shift_full) begin
                // [RQ1] empty shifter loads at once
                lnk.load_byte <= data_in;
                shift_full    <= 1'b1;
            end else begin
                // [RQ15] write lands in buffer
                tx_hold <= data_in;
                tx_full <= 1'b1;
            end
        end
    end

    // ========================================================
    // receive path
    assign rx_room = ~rx_full | data_rd_in;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_buf  <= '0;
            rx_full <= 1'b0;
        end else if (done && rx_room) begin
            // [RQ14] byte into receive buffer
            rx_buf  <= lnk.rx_word;
            rx_full <= 1'b1;
        end else if (data_rd_in) begin
            rx_full <= 1'b0;
        end
    end
    assign rx_data_out = rx_buf;

    // ========================================================
    // flags, set wins over clear
    always_comb begin
        flag_set              = '0;
        // [RQ9] completion flag
        flag_set[FLAG_XFER_DONE] = done;
        // [RQ10] collision flag
        flag_set[FLAG_COLLIDE]   = collide;
        flag_set[FLAG_FAULT]     = mode_fault;
        // [RQ12] overrun, new byte dropped
        flag_set[FLAG_OVERRUN]   = done & ~rx_room & slave_active;
    end

    // [RQ13] only software clears
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= flag_set | (flags & ~flag_clear_in);
        end
    end

    // [RQ13] interrupt request
    assign irq_req_out = int_enable_in & (|flags);

    // status view in control layout
    always_comb begin
        control_out                  = '0;
        control_out[XFER_DONE_BIT]   = flags[FLAG_XFER_DONE];
        control_out[COLLIDE_BIT]     = flags[FLAG_COLLIDE];
        control_out[FAULT_BIT]       = flags[FLAG_FAULT];
        control_out[OVERRUN_BIT]     = flags[FLAG_OVERRUN];
        control_out[SELMODE_LSB+1]   = select_mode[1];
        control_out[SELMODE_LSB]     = select_mode[0];
        control_out[MASTER_BIT]      = master_enable;
        control_out[ENABLE_BIT]      = peripheral_enable;
    end

    // byte in progress on the link
    assign busy_out = slave_active & ~first_sync;

    // ========================================================
    // checks
    immediate_load_a: assert property ( // [RQ1]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        peripheral_enable && data_wr_in && !tx_full && !shift_full
        && !done |=> shift_full && !tx_full
        && lnk.load_byte == $past(data_in))
        else $error("write to idle shifter not loaded at once");

    pending_load_a: assert property ( // [RQ2]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        peripheral_enable && done && tx_full |=> !tx_full
        && shift_full && lnk.load_byte == $past(tx_hold))
        else $error("buffered byte not moved after byte end");

    counter_idle_a: assert property ( // [RQ16]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !slave_active |-> !link_rst_b)
        else $error("link counter not held while disabled");

    done_flag_a: assert property ( // [RQ9]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        done |=> flags[FLAG_XFER_DONE])
        else $error("completion flag missed a byte");

    collide_keep_a: assert property ( // [RQ10]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        collide && !done |=> flags[FLAG_COLLIDE] && $stable(tx_hold)
        && tx_full)
        else $error("collision not flagged or buffer overwritten");

    fault_disable_a: assert property ( // [RQ11]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        mode_fault |=> flags[FLAG_FAULT] && !peripheral_enable
        && !master_enable)
        else $error("mode fault did not disable the unit");

    overrun_keep_a: assert property ( // [RQ12]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        done && rx_full && !data_rd_in && slave_active
        |=> flags[FLAG_OVERRUN] && $stable(rx_buf) && rx_full)
        else $error("overrun lost old byte or not flagged");

    flag_hold_a: assert property ( // [RQ13]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        flags[FLAG_XFER_DONE] && !flag_clear_in[FLAG_XFER_DONE]
        |=> flags[FLAG_XFER_DONE] [*1] ##0 irq_req_out == int_enable_in)
        else $error("flag dropped without software clear");

    rx_take_a: assert property ( // [RQ14]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        done && !rx_full |=> rx_full
        && rx_data_out == $past(lnk.rx_word))
        else $error("received byte not copied to buffer");

    select_gate_a: assert property ( // [RQ4]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        slave_active && four_wire && ss_n_in
        |-> !miso_oe_out && !link_rst_b)
        else $error("link active while deselected");

    rx_steady_a: assert property ( // [RQ14]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !done |=> $stable(rx_buf))
        else $error("receive buffer changed without a finished byte");

    select_open_a: assert property ( // [RQ7]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        slave_active && !four_wire |-> miso_oe_out)
        else $error("three-wire slave stopped driving data out");
endmodule

/* tb/spi_master_model.sv */
`timescale 1ns/1ps
// ============================================================
// behavioural serial master driving the slave's link pins
module spi_master_model #(
    parameter int HALF_NS = 24
) (
    input  wire logic miso_in,   // data from slave
    output logic      sck_out,   // serial clock, idle low
    output logic      mosi_out,  // data to slave
    output logic      ss_n_out   // slave select, low active
);
    // idle levels at time zero
    initial begin
        sck_out  = 1'h0;
        mosi_out = 1'h0;
        ss_n_out = 1'h1;
    end

    // select line held at a level between frames
    task automatic sel(input logic v);
        ss_n_out = v;
    endtask

    // one frame of nbits, msb first; clock stands still outside it
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        input bit use_ss, output logic [7:0] rx);
        rx = 8'h00;
        if (use_ss) begin
            ss_n_out = 1'h0;
        end
        #150;
        for (int i = 0; i < nbits; i++) begin
            mosi_out = tx[7 - i];
            #(HALF_NS);
            rx = {rx[6:0], miso_in};
            sck_out = 1'h1;
            #(HALF_NS);
            sck_out = 1'h0;
        end
        // released line shows the inverse of its last value
        mosi_out = ~mosi_out;
        #(HALF_NS);
        ss_n_out = 1'h1;
        // gap lets the core reload the shifter
        #250;
    endtask
endmodule

/* tb/spi_slave_test.sv */
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the serial slave
module spi_slave_test
    import spi_slave_pkg::*;
;
    logic       core_clk_in, rst_b_in, sck, mosi, ss_n;
    logic       miso_out, miso_oe_out, irq_req_out, busy_out;
    logic       ctrl_wr_in, ctrl_enable_in, ctrl_master_in;
    logic [1:0] ctrl_selmode_in;
    logic [3:0] flag_clear_in;
    logic       int_enable_in, data_wr_in, data_rd_in;
    logic [7:0] data_in, rx_data_out, control_out, rx;
    int         fails, n_compared;

    spi_slave i_spi_slave (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .sck_in(sck), .mosi_in(mosi), .ss_n_in(ss_n),
        .miso_out(miso_out), .miso_oe_out(miso_oe_out),
        .ctrl_wr_in(ctrl_wr_in), .ctrl_enable_in(ctrl_enable_in),
        .ctrl_master_in(ctrl_master_in),
        .ctrl_selmode_in(ctrl_selmode_in),
        .flag_clear_in(flag_clear_in), .int_enable_in(int_enable_in),
        .data_wr_in(data_wr_in), .data_in(data_in),
        .data_rd_in(data_rd_in), .rx_data_out(rx_data_out),
        .control_out(control_out), .irq_req_out(irq_req_out),
        .busy_out(busy_out));
    spi_master_model i_spi_master_model (.miso_in(miso_out),
        .sck_out(sck), .mosi_out(mosi), .ss_n_out(ss_n));

    // ============================================================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic ctrl(input logic en, ms, input logic [1:0] sm);
        @(posedge core_clk_in);
        ctrl_enable_in  <= en;
        ctrl_master_in  <= ms;
        ctrl_selmode_in <= sm;
        ctrl_wr_in      <= 1'h1;
        @(posedge core_clk_in);
        ctrl_wr_in <= 1'h0;
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge core_clk_in);
        data_in    <= d;
        data_wr_in <= 1'h1;
        @(posedge core_clk_in);
        data_wr_in <= 1'h0;
    endtask
    // read receive buffer and clear every flag in the same cycle
    task automatic clr();
        @(posedge core_clk_in);
        data_rd_in    <= 1'h1;
        flag_clear_in <= 4'hF;
        @(posedge core_clk_in);
        data_rd_in    <= 1'h0;
        flag_clear_in <= 4'h0;
        cyc(1);
    endtask
    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        chk(control_out, 8'h04);
        chk(rx_data_out, 8'h00);
        chk({5'h00, busy_out, irq_req_out, miso_oe_out}, 8'h00);
    endtask
    task automatic t_four_wire();
        ctrl(1'h1, 1'h0, SEL_FOUR_WIRE);
        chk(control_out, 8'h05);
        chk({7'h00, miso_oe_out}, 8'h00);
        i_spi_master_model.sel(1'h0);
        cyc(4);
        chk({7'h00, miso_oe_out}, 8'h01);
        i_spi_master_model.sel(1'h1);
        wr(8'hA5);
        i_spi_master_model.xfer(8'h3C, 8, 1'b1, rx);
        chk(rx, 8'hA5);
        cyc(6);
        chk(rx_data_out, 8'h3C);
        chk(control_out[7:4], 4'h8);
        @(posedge core_clk_in);
        int_enable_in <= 1'h1;
        cyc(1);
        chk({7'h00, irq_req_out}, 8'h01);
        clr();
        i_spi_master_model.xfer(8'hFF, 8, 1'b0, rx);
        cyc(6);
        chk(control_out[7:4], 4'h0);
    endtask
    task automatic t_double_buffer();
        wr(8'h11);
        wr(8'h22);
        wr(8'h33);
        cyc(1);
        chk(control_out[6], 1'h1);
        i_spi_master_model.xfer(8'h01, 8, 1'b1, rx);
        chk(rx, 8'h11);
        cyc(6);
        i_spi_master_model.xfer(8'h02, 8, 1'b1, rx);
        chk(rx, 8'h22);
        cyc(6);
        chk(rx_data_out, 8'h01);
        chk(control_out[7:4], 4'hD);
        clr();
        chk(control_out[7:4], 4'h0);
    endtask
    task automatic t_select_fall();
        i_spi_master_model.xfer(8'hF0, 4, 1'b1, rx);
        i_spi_master_model.xfer(8'h96, 8, 1'b1, rx);
        cyc(6);
        chk(rx_data_out, 8'h96);
        chk(control_out[7:4], 4'h8);
        clr();
    endtask
    task automatic t_three_wire();
        ctrl(1'h1, 1'h0, SEL_THREE_WIRE);
        chk({7'h00, miso_oe_out}, 8'h01);
        wr(8'hC3);
        i_spi_master_model.xfer(8'h69, 8, 1'b0, rx);
        chk(rx, 8'hC3);
        cyc(6);
        chk(rx_data_out, 8'h69);
        clr();
        i_spi_master_model.xfer(8'h00, 3, 1'b0, rx);
        chk({7'h00, busy_out}, 8'h01);
        ctrl(1'h0, 1'h0, SEL_THREE_WIRE);
        chk({7'h00, busy_out}, 8'h00);
        i_spi_master_model.xfer(8'hFF, 8, 1'b0, rx);
        cyc(6);
        chk(control_out[7:4], 4'h0);
        ctrl(1'h1, 1'h0, SEL_THREE_WIRE);
        i_spi_master_model.xfer(8'hB4, 8, 1'b0, rx);
        cyc(6);
        chk(rx_data_out, 8'hB4);
        clr();
    endtask
    task automatic t_mode_fault();
        ctrl(1'h1, 1'h1, SEL_THREE_WIRE);
        i_spi_master_model.sel(1'h0);
        cyc(6);
        chk(control_out[5], 1'h1);
        chk(control_out[1:0], 2'h0);
        chk({7'h00, irq_req_out}, 8'h01);
        i_spi_master_model.sel(1'h1);
    endtask

    // ============================================================
    // clock, reset and main sequence
    initial begin
        core_clk_in = 1'h0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    initial begin
        fails = 0;
        n_compared = 0;
        rst_b_in = 1'h0;
        ctrl_wr_in = 1'h0;
        ctrl_enable_in = 1'h0;
        ctrl_master_in = 1'h0;
        ctrl_selmode_in = 2'h1;
        flag_clear_in = 4'h0;
        int_enable_in = 1'h0;
        data_wr_in = 1'h0;
        data_rd_in = 1'h0;
        data_in = 8'h00;
        repeat (12) @(posedge core_clk_in);
        rst_b_in <= 1'h1;
        cyc(1);
        t_reset();
        t_four_wire();
        t_double_buffer();
        t_select_fall();
        t_three_wire();
        t_mode_fault();
        report_and_stop();
    end
    // watchdog well beyond the expected run
    initial begin
        #500000;
        fails++;
        report_and_stop();
    end
endmodule
